// file: design/cxm_pkg.sv
package cxm_pkg;

  // ***************************************************************
  // Timing base
  // ***************************************************************
  localparam int unsigned CXM_CLK_PERIOD_PS = 10000;

  // Shortest dominant pulse counted in pattern wake, ns (strictly longer)
  localparam int unsigned CXM_PULSE_MIN_NS = 500;
  localparam int unsigned CXM_PULSE_MIN_CYC =
    (CXM_PULSE_MIN_NS * 1000) / CXM_CLK_PERIOD_PS + 1;

  // Single dominant pulse length for single pulse wake, ns
  localparam int unsigned CXM_PULSE_ONE_NS = 2000;
  localparam int unsigned CXM_PULSE_ONE_CYC =
    (CXM_PULSE_ONE_NS * 1000 + CXM_CLK_PERIOD_PS - 1) / CXM_CLK_PERIOD_PS;

  // Pattern window, us (longest time, rounds down)
  localparam int unsigned CXM_WAKE_WIN_US = 120;
  localparam int unsigned CXM_WAKE_WIN_CYC =
    (CXM_WAKE_WIN_US * 1000000) / CXM_CLK_PERIOD_PS;

  // Interrupt pulse length, ns
  localparam int unsigned CXM_INT_PULSE_NS = 1000;
  localparam int unsigned CXM_INT_PULSE_CYC =
    (CXM_INT_PULSE_NS * 1000) / CXM_CLK_PERIOD_PS;

  // Counter widths
  localparam int unsigned CXM_PULSE_CNT_W = 8;
  localparam int unsigned CXM_WIN_CNT_W = 14;
  localparam int unsigned CXM_INT_CNT_W = 8;

  // Pulses making one wake pattern
  localparam logic [1:0] CXM_PATTERN_PULSES = 2'h3;

  // ***************************************************************
  // Slew rate codes
  // ***************************************************************
  localparam logic [1:0] CXM_SLEW_FAST = 2'h0;
  localparam logic [1:0] CXM_SLEW_MID = 2'h1;
  localparam logic [1:0] CXM_SLEW_SLOW = 2'h2;
  localparam logic [1:0] CXM_SLEW_RESET = CXM_SLEW_FAST;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [1:0] {
    CXM_MODE_TXRX,
    CXM_MODE_RXONLY,
    CXM_MODE_SLEEP
  } cxm_mode_t;

  // Bus side controls to the analog front end
  typedef struct packed {
    logic drv_en;
    logic dominant;
    logic bias_mid;
    logic term_gnd;
    logic split_en;
  } cxm_bus_ctrl_t;

  localparam cxm_bus_ctrl_t CXM_BUS_CTRL_RESET = '{
    drv_en: 1'b0, dominant: 1'b0, bias_mid: 1'b0,
    term_gnd: 1'b1, split_en: 1'b0};

endpackage

// file: design/cxm_pulse_qual.sv
`timescale 1ns/1ps
module cxm_pulse_qual
#(
  parameter int unsigned CNT_W = 8,
  parameter int unsigned THRESH = 51
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Dominant level in, qualified hit out
  input wire logic dom,
  output logic hit
);

  localparam logic [CNT_W-1:0] THR = CNT_W'(THRESH);
  localparam logic [CNT_W-1:0] THR_M1 = CNT_W'(THRESH - 1);

  logic [CNT_W-1:0] cnt_r;

  // One pulse per dominant phase once it has lasted THRESH cycles
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= '0;
      hit <= 1'b0;
    end
    else
    begin
      hit <= dom && (cnt_r == THR_M1);
      if (!dom)
        cnt_r <= '0;
      else if (cnt_r != THR)
        cnt_r <= cnt_r + CNT_W'(1);
    end
  end

endmodule

// file: design/cxm_can_phy.sv
`timescale 1ns/1ps
module cxm_can_phy
#(
  parameter int unsigned WAKE_WIN_CYC = cxm_pkg::CXM_WAKE_WIN_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Mode and configuration
  input cxm_pkg::cxm_mode_t mode,
  input wire logic slew_wr,
  input wire logic [1:0] slew_sel,
  input wire logic wake_en,
  input wire logic single_pulse_wake_select,
  input wire logic low_power_mode,
  input wire logic wake_flag_clr,
  // Controller side
  input wire logic txd,
  output logic rxd,
  // Bus side
  input wire logic bus_dom,
  output cxm_pkg::cxm_bus_ctrl_t bus_ctrl,
  output logic [1:0] slew,
  output logic wake_rx_en,
  // Status
  output logic wake_flag,
  output logic int_n,
  output logic wake_req
);
  import cxm_pkg::*;

  typedef enum logic {W_IDLE, W_PAT} cxm_wstate_t;

  localparam logic [CXM_WIN_CNT_W-1:0] WIN_LAST =
    CXM_WIN_CNT_W'(WAKE_WIN_CYC - 1);
  localparam logic [CXM_INT_CNT_W-1:0] INT_LOAD =
    CXM_INT_CNT_W'(CXM_INT_PULSE_CYC - 1);

  // ***************************************************************
  // Mode decode and driver control
  // ***************************************************************
  wire is_txrx = (mode == CXM_MODE_TXRX);
  wire is_sleep = (mode == CXM_MODE_SLEEP);
  logic drv_armed_r;
  cxm_bus_ctrl_t bus_ctrl_nxt;

  // Arm the driver once TXD seen recessive in normal mode
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      drv_armed_r <= 1'b0;
    else
      drv_armed_r <= is_txrx && (drv_armed_r || txd);
  end

  // Receive only leaves driver off whatever TXD does
  assign bus_ctrl_nxt.drv_en = is_txrx && (drv_armed_r || txd);
  assign bus_ctrl_nxt.dominant = bus_ctrl_nxt.drv_en && !txd;
  assign bus_ctrl_nxt.bias_mid = !is_sleep;
  assign bus_ctrl_nxt.term_gnd = is_sleep;
  assign bus_ctrl_nxt.split_en = !is_sleep;

  // Bus controls and receiver output
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus_ctrl <= CXM_BUS_CTRL_RESET;
      rxd <= 1'b1;
      wake_rx_en <= 1'b0;
    end
    else
    begin
      bus_ctrl <= bus_ctrl_nxt;
      rxd <= !bus_dom;
      wake_rx_en <= is_sleep && wake_en;
    end
  end

  // ***************************************************************
  // Slew rate selection
  // ***************************************************************
  wire slew_ok = slew_wr && (slew_sel != 2'h3);

  // Holds fastest until software writes a legal code
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      slew <= CXM_SLEW_RESET;
    else if (slew_ok)
      slew <= slew_sel;
  end

  // ***************************************************************
  // Wake-up detection
  // ***************************************************************
  wire wake_active = is_sleep && wake_en;
  wire wake_dom = bus_dom && wake_active;
  logic short_hit;
  logic long_hit;

  // Pattern pulse qualifier, strictly longer than minimum
  cxm_pulse_qual #(
    .CNT_W(CXM_PULSE_CNT_W),
    .THRESH(CXM_PULSE_MIN_CYC)
  ) u_short (
    .clk(clk),
    .rstn(rstn),
    .dom(wake_dom),
    .hit(short_hit)
  );

  // Single pulse qualifier
  cxm_pulse_qual #(
    .CNT_W(CXM_PULSE_CNT_W),
    .THRESH(CXM_PULSE_ONE_CYC)
  ) u_long (
    .clk(clk),
    .rstn(rstn),
    .dom(wake_dom),
    .hit(long_hit)
  );

  cxm_wstate_t wst_r;
  cxm_wstate_t wst_nxt;
  logic [1:0] pcnt_r;
  logic [1:0] pcnt_nxt;
  logic [CXM_WIN_CNT_W-1:0] win_r;
  logic [CXM_WIN_CNT_W-1:0] win_nxt;
  logic pat_wake;
  wire pat_mode = wake_active && !single_pulse_wake_select;
  wire win_end = (win_r == WIN_LAST);
  wire single_wake = wake_active && single_pulse_wake_select && long_hit;
  wire wake_evt = pat_wake || single_wake;

  // Pattern state machine: counts pulses inside the window
  always_comb
  begin
    wst_nxt = wst_r;
    pcnt_nxt = pcnt_r;
    win_nxt = win_r;
    pat_wake = 1'b0;
    case (wst_r)
      W_IDLE:
      begin
        if (pat_mode && short_hit)
        begin
          wst_nxt = W_PAT;
          pcnt_nxt = 2'h1;
          win_nxt = '0;
        end
      end
      W_PAT:
      begin
        win_nxt = win_r + CXM_WIN_CNT_W'(1);
        if (!pat_mode)
        begin
          wst_nxt = W_IDLE;
          pcnt_nxt = 2'h0;
        end
        else if (win_end)
        begin
          wst_nxt = short_hit ? W_PAT : W_IDLE;
          pcnt_nxt = short_hit ? 2'h1 : 2'h0;
          win_nxt = '0;
        end
        else if (short_hit && (pcnt_r == CXM_PATTERN_PULSES - 2'h1))
        begin
          pat_wake = 1'b1;
          wst_nxt = W_IDLE;
          pcnt_nxt = 2'h0;
        end
        else if (short_hit)
          pcnt_nxt = pcnt_r + 2'h1;
      end
      default:
      begin
        wst_nxt = W_IDLE;
        pcnt_nxt = 2'h0;
      end
    endcase
  end

  // Pattern state registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wst_r <= W_IDLE;
      pcnt_r <= 2'h0;
      win_r <= '0;
    end
    else
    begin
      wst_r <= wst_nxt;
      pcnt_r <= pcnt_nxt;
      win_r <= win_nxt;
    end
  end

  // ***************************************************************
  // Wake reporting
  // ***************************************************************
  logic [CXM_INT_CNT_W-1:0] int_cnt_r;

  // Sticky flag (set beats clear), interrupt pulse, wake request
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wake_flag <= 1'b0;
      int_n <= 1'b1;
      int_cnt_r <= '0;
      wake_req <= 1'b0;
    end
    else
    begin
      wake_flag <= wake_evt || (wake_flag && !wake_flag_clr);
      wake_req <= wake_evt && low_power_mode;
      if (wake_evt)
      begin
        int_cnt_r <= INT_LOAD;
        int_n <= 1'b0;
      end
      else if (int_cnt_r != '0)
      begin
        int_cnt_r <= int_cnt_r - CXM_INT_CNT_W'(1);
        int_n <= 1'b0;
      end
      else
        int_n <= 1'b1;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_drv_gate: assert property (
    bus_ctrl.drv_en |-> $past(is_txrx && (txd || bus_ctrl.drv_en)))
    else $error("driver enabled without arming");
  chk_recessive_tx: assert property (
    is_txrx && txd |=> !bus_ctrl.dominant && bus_ctrl.bias_mid)
    else $error("recessive not held with txd high");
  chk_dominant_tx: assert property (
    is_txrx && drv_armed_r && !txd |=> bus_ctrl.dominant && bus_ctrl.drv_en)
    else $error("dominant not driven with txd low");
  chk_rxd_level: assert property (
    ##1 rxd == !$past(bus_dom))
    else $error("rxd does not follow bus");
  chk_rxonly_off: assert property (
    mode == CXM_MODE_RXONLY |=> !bus_ctrl.drv_en && bus_ctrl.split_en)
    else $error("driver active in receive only");
  chk_sleep_bus: assert property (
    is_sleep |=> bus_ctrl.term_gnd && !bus_ctrl.split_en && !bus_ctrl.drv_en)
    else $error("sleep bus state wrong");
  chk_slew_hold: assert property (
    !slew_ok |=> slew == $past(slew))
    else $error("slew changed without write");
  chk_wake_report: assert property (
    wake_evt |=> wake_flag && !int_n ##1 !int_n)
    else $error("wake not reported");
  chk_wake_gate: assert property (
    $rose(wake_flag) |-> $past(is_sleep && wake_en))
    else $error("wake outside sleep or disabled");
  chk_single_time: assert property (
    single_wake |-> $past(wake_dom, CXM_PULSE_ONE_CYC))
    else $error("single wake too early");
  chk_window_clear: assert property (
    wst_r == W_PAT && win_end && !short_hit |=> pcnt_r == 2'h0)
    else $error("count not cleared at window end");

  cov_pattern_wake: cover property (pat_wake);
  cov_single_wake: cover property (single_wake);
  cov_window_expiry: cover property (wst_r == W_PAT && win_end);
  cov_lp_wake: cover property (wake_req);

endmodule

// file: tb/cxm_ctrl_model.sv
`timescale 1ns/1ps
// Protocol controller stand-in: shifts a 12 bit frame onto txd
module cxm_ctrl_model
#(
  parameter int unsigned BIT_CYC = 4
)
(
  // Clock
  input wire logic clk,
  // Frame request
  input wire logic go,
  input wire logic [11:0] bits,
  // Controller pins
  output logic txd,
  output logic busy
);
  int unsigned n;
  // Frame MSB first, recessive when idle; go taken on rising edge
  initial
  begin
    txd = 1'b1;
    busy = 1'b0;
    forever
    begin
      @(posedge clk);
      if (go)
      begin
        busy = 1'b1;
        for (n = 0; n < 12 * BIT_CYC; n++)
        begin
          @(negedge clk);
          txd = bits[11 - n / BIT_CYC];
        end
        @(negedge clk);
        txd = 1'b1;
        busy = 1'b0;
      end
    end
  end
endmodule

// file: tb/cxm_can_phy_bench.sv
`timescale 1ns/1ps
module cxm_can_phy_bench;
  import cxm_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  cxm_mode_t mode = CXM_MODE_SLEEP;
  logic slew_wr = 1'b0;
  logic [1:0] slew_sel = 2'h0;
  logic wake_en = 1'b0;
  logic single_pulse_wake_select = 1'b0;
  logic low_power_mode = 1'b0;
  logic wake_flag_clr = 1'b0;
  logic txd, rxd, bus_dom = 1'b0, go = 1'b0, busy, txd_q = 1'b1;
  logic [11:0] bits = 12'h0;
  cxm_bus_ctrl_t bus_ctrl;
  logic [1:0] slew;
  logic wake_rx_en, wake_flag, int_n, wake_req, req;
  int fail_count = 0;
  int check_count = 0;
  int n;
  // ****
  // Clock, partner, design
  // ****
  always #5 clk = ~clk;
  always @(posedge clk) txd_q <= txd;
  cxm_ctrl_model ctrl_u (.clk(clk), .go(go), .bits(bits), .txd(txd),
    .busy(busy));
  cxm_can_phy #(.WAKE_WIN_CYC(600)) dut_u (.clk(clk), .rstn(rstn),
    .mode(mode), .slew_wr(slew_wr), .slew_sel(slew_sel),
    .wake_en(wake_en), .single_pulse_wake_select(single_pulse_wake_select),
    .low_power_mode(low_power_mode), .wake_flag_clr(wake_flag_clr),
    .txd(txd), .rxd(rxd), .bus_dom(bus_dom), .bus_ctrl(bus_ctrl),
    .slew(slew), .wake_rx_en(wake_rx_en), .wake_flag(wake_flag),
    .int_n(int_n), .wake_req(wake_req));
  // ****
  // Helpers
  // ****
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task pulse(input int len);
    bus_dom = 1'b1;
    cyc(len);
    bus_dom = 1'b0;
    cyc(20);
  endtask
  // Hold bus dominant until the flag rises, bounded
  task wake_wait(input int lim);
    req = 1'b0;
    bus_dom = 1'b1;
    for (n = 0; n < lim; n++)
    begin
      @(negedge clk);
      req = req | wake_req;
      if (wake_flag === 1'b1)
        break;
    end
    bus_dom = 1'b0;
    if (n == lim)
    begin
      chk({7'h0, wake_flag}, 8'h01);
      conclude();
    end
  endtask
  task clr_flag;
    wake_flag_clr = 1'b1;
    cyc(1);
    wake_flag_clr = 1'b0;
    cyc(1);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task t_drive;
    mode = CXM_MODE_RXONLY;
    bits = 12'h000;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(5);
    chk({7'h0, bus_ctrl.drv_en}, 8'h00);
    chk({7'h0, bus_ctrl.split_en}, 8'h01);
    for (n = 0; n < 2; n++)
    begin
      bus_dom = n[0];
      cyc(2);
      chk({7'h0, rxd}, {7'h0, ~n[0]});
    end
    bus_dom = 1'b0;
    mode = CXM_MODE_TXRX;
    cyc(5);
    chk({7'h0, bus_ctrl.drv_en}, 8'h00);
    for (n = 0; n < 80 && busy; n++)
      cyc(1);
    chk({7'h0, busy}, 8'h00);
    cyc(2);
    chk({3'h0, bus_ctrl}, 8'h15);
    bits = 12'h5a3;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    for (n = 0; n < 50; n++)
    begin
      cyc(1);
      chk({6'h0, bus_ctrl.drv_en, bus_ctrl.dominant},
        {7'h1, ~txd_q});
    end
    $display("drive test done");
  endtask
  task t_slew;
    logic [1:0] codes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [1:0] exps [4] = '{2'h1, 2'h2, 2'h2, 2'h0};
    for (n = 0; n < 4; n++)
    begin
      slew_wr = 1'b1;
      slew_sel = codes[n];
      cyc(1);
      slew_wr = 1'b0;
      cyc(1);
      chk({6'h0, slew}, {6'h0, exps[n]});
    end
    $display("slew test done");
  endtask
  task t_sleep;
    mode = CXM_MODE_SLEEP;
    cyc(3);
    chk({3'h0, bus_ctrl}, 8'h02);
    chk({7'h0, wake_rx_en}, 8'h00);
    pulse(60);
    pulse(60);
    pulse(60);
    chk({7'h0, wake_flag}, 8'h00);
    wake_en = 1'b1;
    low_power_mode = 1'b1;
    cyc(2);
    chk({7'h0, wake_rx_en}, 8'h01);
    pulse(40);
    pulse(60);
    pulse(40);
    pulse(60);
    chk({7'h0, wake_flag}, 8'h00);
    wake_wait(80);
    chk({6'h0, req, int_n}, 8'h02);
    cyc(110);
    chk({7'h0, int_n}, 8'h01);
    clr_flag();
    chk({7'h0, wake_flag}, 8'h00);
    pulse(60);
    pulse(60);
    cyc(650);
    pulse(60);
    chk({7'h0, wake_flag}, 8'h00);
    pulse(60);
    wake_wait(80);
    clr_flag();
    single_pulse_wake_select = 1'b1;
    low_power_mode = 1'b0;
    pulse(150);
    chk({7'h0, wake_flag}, 8'h00);
    wake_wait(260);
    chk({7'h0, n >= 195 && n <= 210}, 8'h01);
    chk({7'h0, req}, 8'h00);
    $display("sleep test done");
  endtask
  task t_return;
    mode = CXM_MODE_TXRX;
    cyc(3);
    chk({2'h0, wake_rx_en, bus_ctrl}, 8'h15);
    $display("return test done");
  endtask
  // Main sequence
  initial
  begin
    cyc(8);
    chk({2'h0, slew, int_n, rxd, wake_flag, wake_req}, 8'h0c);
    rstn = 1'b1;
    cyc(1);
    t_drive();
    t_slew();
    t_sleep();
    t_return();
    conclude();
  end
endmodule
